// ==== core/dam_defines.vh ====
// Purpose: Constants for the diagnostic alarm manager.
// Assumes: 100 MHz sys_clk, asynchronous active-low reset.
// Notes:   Flag indices select bits of the flag, enable and status vectors.
// Function
// - Every check has its own interrupt enable.
// - Interrupt events can also drive analog outputs into diagnostic state.
// - Sticky flags persist until power-on reset or a granted clear path.
// - Self-clearing flags drop when their cause disappears.
// - Continuous checks run always; start-up checks only once at power-up.
// - Supply over/under-voltage and analog under-voltage are self-clearing flags.
// - Serial protocol, data access and internal bus failures self-clear.
// - Shadow register double error sticky, single error corrected, self-clearing.
// - Start-up memory check: double error sticky, single corrected, self-clearing.
// - Registers and memories use single-correct, double-detect code with alarms.
// - Measured oscillator value outside programmed limits raises self-clearing flag.
// - Stopped transmitter oscillator self-clears; internal oscillator failure is sticky.
// - Watchdog sets a sticky flag at first expiry, restarts on expiry, zero value stops it.
// - Output mean offset fault self-clears and turns the outputs off once it holds for a whole check window.
// - Offset fault persisting eight checks latches permanent shutdown and sticky flag.
// - Permanent offset shutdown ends on reset or controller clearing sticky flag.
// - Overcurrent sets self-clearing flag; after assert debounce all outputs tri-state.
// - After retry debounce outputs re-enable to recheck overcurrent.
// - Overload persisting eight checks latches shutdown; cleared by reset or controller.
// - Coil faults and junction temperature faults are self-clearing flags.
// - Gain loop reaching a programmed limit raises a self-clearing flag.
// - Die damage, internal supply, digital error, self-test failure are sticky.
// - Output diagnostics select: disabled, true pins, complement pins, all four.
// - Each error has its own enable for output diagnostic indication.
// - Enabled error with diagnostics on switches selected drivers off.
`ifndef DAM_DEFINES_VH
`define DAM_DEFINES_VH

`define DAM_NFLAG            28
`define DAM_F_OVERVOLT       0
`define DAM_F_UNDERVOLT      1
`define DAM_F_ANA_UNDERVOLT  2
`define DAM_F_DATA_ACCESS    3
`define DAM_F_PROTOCOL       4
`define DAM_F_SHADOW_DED     5
`define DAM_F_SHADOW_SED     6
`define DAM_F_NVM_DED        7
`define DAM_F_NVM_SED        8
`define DAM_F_OSC_FREQ       9
`define DAM_F_OSC_STOP       10
`define DAM_F_INT_OSC        11
`define DAM_F_INT_BUS        12
`define DAM_F_WATCHDOG       13
`define DAM_F_MECH_DAMAGE    14
`define DAM_F_BUF_TEMP       15
`define DAM_F_BUF_STICKY     16
`define DAM_F_OVL_TEMP       17
`define DAM_F_OVL_STICKY     18
`define DAM_F_RX_COIL        19
`define DAM_F_TX_COIL        20
`define DAM_F_JUNC_TEMP      21
`define DAM_F_INT_SUPPLY     22
`define DAM_F_GAIN_LOOP      23
`define DAM_F_DIGITAL        24
`define DAM_F_SELF_TEST      25
`define DAM_F_SHADOW_CODE    26
`define DAM_F_NVM_CODE       27

`define DAM_DIAG_OFF         2'h0
`define DAM_DIAG_TRUE        2'h1
`define DAM_DIAG_COMP        2'h2
`define DAM_DIAG_ALL         2'h3

`define DAM_RETRY_LIMIT      4'h8
`define DAM_OC_ASSERT_NS     10000
`define DAM_OC_RETRY_NS      1000000
`define DAM_CLK_PERIOD_NS    10
`define DAM_BUF_CHECK_NS     100000

`endif

// ==== core/dam_ecc_check.v ====
// Purpose: Hamming SEC-DED check and single-bit correction of a 32-bit word.
// Assumes: Code word is 32 data bits plus 7 check bits.
// Notes:   Purely combinational.
`timescale 1ns/1ns
module dam_ecc_check (
  data_in,
  check_in,
  data_out,
  single_err,
  double_err
);
  input  wire [31:0] data_in;
  input  wire [6:0]  check_in;
  output reg  [31:0] data_out;
  output reg         single_err;
  output reg         double_err;

  reg [38:0] cw;
  reg [5:0]  syn;
  reg        par;
  integer    i;
  integer    d;

  always @* begin
    cw  = 39'h00_0000_0000;
    syn = 6'h00;
    d   = 0;
    // Data occupies non-power-of-two positions 3..38 of a 1-based word.
    for (i = 1; i < 39; i = i + 1) begin
      if ((i & (i - 1)) != 0) begin
        cw[i] = data_in[d];
        d     = d + 1;
      end
    end
    for (i = 0; i < 6; i = i + 1) begin
      cw[(1 << i)] = check_in[i];
    end
    for (i = 1; i < 39; i = i + 1) begin
      if (cw[i]) begin
        syn = syn ^ i[5:0];
      end
    end
    par = (^cw[38:1]) ^ check_in[6];
    single_err = par;
    double_err = (syn != 6'h00) && !par;
    if (par && (syn != 6'h00) && (syn < 6'd39)) begin
      cw[syn] = ~cw[syn];
    end
    data_out = 32'h0000_0000;
    d = 0;
    for (i = 1; i < 39; i = i + 1) begin
      if ((i & (i - 1)) != 0) begin
        data_out[d] = cw[i];
        d           = d + 1;
      end
    end
  end
endmodule // dam_ecc_check

// ==== core/dam_retry_guard.v ====
// Purpose: Retry counter and permanent shutdown for one output protection.
// Assumes: fault_now is already synchronised to sys_clk.
// Notes:   A check is counted when fault is seen at the end of an on-window.
`timescale 1ns/1ns
`include "dam_defines.vh"
module dam_retry_guard #(
  parameter ON_CYCLES  = 1000,
  parameter OFF_CYCLES = 100000,
  parameter CNT_W      = 20
) (
  sys_clk,
  rst_n,
  fault_now,
  clear_sticky,
  outputs_off,
  temp_flag,
  sticky_flag
);
  input  wire sys_clk;
  input  wire rst_n;
  input  wire fault_now;
  input  wire clear_sticky;
  output wire outputs_off;
  output wire temp_flag;
  output reg  sticky_flag;

  localparam ST_RUN  = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_OFF  = 2'h2;
  localparam ST_LOCK = 2'h3;

  reg [1:0]       state;
  reg [CNT_W-1:0] timer;
  reg [3:0]       retries;

  assign temp_flag   = fault_now;
  assign outputs_off = (state == ST_OFF) || (state == ST_LOCK);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ST_RUN;
      timer       <= {CNT_W{1'b0}};
      retries     <= 4'h0;
      sticky_flag <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          timer <= {CNT_W{1'b0}};
          if (fault_now) begin
            state <= ST_WAIT;
          end else begin
            retries <= 4'h0;
          end
        end
        ST_WAIT: begin
          // The fault must hold for the whole debounce to count as a check.
          if (!fault_now) begin
            state <= ST_RUN;
          end else if (timer == ON_CYCLES[CNT_W-1:0] - 1'b1) begin
            timer <= {CNT_W{1'b0}};
            if (retries == `DAM_RETRY_LIMIT - 4'h1) begin
              state       <= ST_LOCK;
              sticky_flag <= 1'b1;
            end else begin
              retries <= retries + 4'h1;
              state   <= ST_OFF;
            end
          end else begin
            timer <= timer + 1'b1;
          end
        end
        ST_OFF: begin
          if (timer == OFF_CYCLES[CNT_W-1:0] - 1'b1) begin
            timer <= {CNT_W{1'b0}};
            state <= ST_RUN;
          end else begin
            timer <= timer + 1'b1;
          end
        end
        ST_LOCK: begin
          if (clear_sticky) begin
            sticky_flag <= 1'b0;
            retries     <= 4'h0;
            state       <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end
endmodule // dam_retry_guard

// ==== core/dam_top.v ====
// Purpose: Collects diagnostic faults, drives interrupt pin and output shutdown.
// Assumes: Fault inputs come from analog or other domains and are synchronised.
// Notes:   Serial register access lives elsewhere; controls here are ports.
`timescale 1ns/1ns
`include "dam_defines.vh"
module dam_top #(
  parameter NF           = `DAM_NFLAG,
  parameter FREQ_W       = 16,
  parameter GAIN_W       = 8,
  parameter WD_W         = 24,
  parameter OC_ASSERT_CYC =
    (`DAM_OC_ASSERT_NS + `DAM_CLK_PERIOD_NS - 1) / `DAM_CLK_PERIOD_NS,
  parameter OC_RETRY_CYC  = `DAM_OC_RETRY_NS / `DAM_CLK_PERIOD_NS,
  parameter BUF_CHECK_CYC =
    (`DAM_BUF_CHECK_NS + `DAM_CLK_PERIOD_NS - 1) / `DAM_CLK_PERIOD_NS,
  parameter STARTUP_CYC  = 16
) (
  sys_clk,
  rst_n,
  overvolt_in,
  undervolt_in,
  ana_undervolt_in,
  data_access_in,
  protocol_fail_in,
  int_bus_in,
  int_osc_fail_in,
  osc_stop_in,
  rx_coil_in,
  tx_coil_in,
  junc_temp_in,
  mech_damage_in,
  int_supply_in,
  digital_err_in,
  self_test_fail_in,
  mean_offset_in,
  overcurrent_in,
  shadow_data,
  shadow_check,
  shadow_corrected,
  nvm_data,
  nvm_check,
  nvm_valid,
  nvm_corrected,
  osc_freq_meas,
  osc_freq_lo,
  osc_freq_hi,
  osc_freq_value,
  gain_now,
  gain_lo,
  gain_hi,
  wd_value,
  irq_enable,
  diag_enable,
  diag_mode,
  clear_buf_sticky,
  clear_ovl_sticky,
  flags,
  startup_done,
  irq_pin_out,
  irq_pin_oe_n,
  sine_pos_oe_n,
  sine_neg_oe_n,
  cos_pos_oe_n,
  cos_neg_oe_n
);
  input  wire              sys_clk;
  input  wire              rst_n;
  input  wire              overvolt_in;
  input  wire              undervolt_in;
  input  wire              ana_undervolt_in;
  input  wire              data_access_in;
  input  wire              protocol_fail_in;
  input  wire              int_bus_in;
  input  wire              int_osc_fail_in;
  input  wire              osc_stop_in;
  input  wire              rx_coil_in;
  input  wire              tx_coil_in;
  input  wire              junc_temp_in;
  input  wire              mech_damage_in;
  input  wire              int_supply_in;
  input  wire              digital_err_in;
  input  wire              self_test_fail_in;
  input  wire              mean_offset_in;
  input  wire              overcurrent_in;
  input  wire [31:0]       shadow_data;
  input  wire [6:0]        shadow_check;
  output reg  [31:0]       shadow_corrected;
  input  wire [31:0]       nvm_data;
  input  wire [6:0]        nvm_check;
  input  wire              nvm_valid;
  output reg  [31:0]       nvm_corrected;
  input  wire [FREQ_W-1:0] osc_freq_meas;
  input  wire [FREQ_W-1:0] osc_freq_lo;
  input  wire [FREQ_W-1:0] osc_freq_hi;
  output reg  [FREQ_W-1:0] osc_freq_value;
  input  wire [GAIN_W-1:0] gain_now;
  input  wire [GAIN_W-1:0] gain_lo;
  input  wire [GAIN_W-1:0] gain_hi;
  input  wire [WD_W-1:0]   wd_value;
  input  wire [NF-1:0]     irq_enable;
  input  wire [NF-1:0]     diag_enable;
  input  wire [1:0]        diag_mode;
  input  wire              clear_buf_sticky;
  input  wire              clear_ovl_sticky;
  output reg  [NF-1:0]     flags;
  output reg               startup_done;
  output wire              irq_pin_out;
  output wire              irq_pin_oe_n;
  output wire              sine_pos_oe_n;
  output wire              sine_neg_oe_n;
  output wire              cos_pos_oe_n;
  output wire              cos_neg_oe_n;

  // ---------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------
  localparam NS = 17;
  wire [NS-1:0] raw_in = {overcurrent_in, mean_offset_in, self_test_fail_in,
    digital_err_in, int_supply_in, mech_damage_in, junc_temp_in, tx_coil_in,
    rx_coil_in, osc_stop_in, int_osc_fail_in, int_bus_in, protocol_fail_in,
    data_access_in, ana_undervolt_in, undervolt_in, overvolt_in};
  reg [NS-1:0] sync_a;
  reg [NS-1:0] sync_b;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= {NS{1'b0}};
      sync_b <= {NS{1'b0}};
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // ---------------------------------------------------------------------
  // Code checks on shadow registers and memory
  // ---------------------------------------------------------------------
  wire [31:0] sh_fix;
  wire        sh_sed;
  wire        sh_ded;
  wire [31:0] nv_fix;
  wire        nv_sed;
  wire        nv_ded;

  dam_ecc_check u_shadow_ecc (
    .data_in    (shadow_data),
    .check_in   (shadow_check),
    .data_out   (sh_fix),
    .single_err (sh_sed),
    .double_err (sh_ded)
  );

  dam_ecc_check u_nvm_ecc (
    .data_in    (nvm_data),
    .check_in   (nvm_check),
    .data_out   (nv_fix),
    .single_err (nv_sed),
    .double_err (nv_ded)
  );

  // ---------------------------------------------------------------------
  // Start-up window
  // ---------------------------------------------------------------------
  reg [7:0] su_count;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      su_count     <= 8'h00;
      startup_done <= 1'b0;
    end else if (!startup_done) begin
      su_count <= su_count + 8'h01;
      if (su_count == STARTUP_CYC[7:0] - 8'h01) begin
        startup_done <= 1'b1;
      end
    end
  end

  // The memory words are only read during start-up, so outside it the
  // start-up flags keep whatever the last check found.
  wire nvm_chk = nvm_valid && !startup_done;

  // ---------------------------------------------------------------------
  // Oscillator frequency, gain limits and watchdog
  // ---------------------------------------------------------------------
  wire freq_bad = (osc_freq_value < osc_freq_lo) ||
                  (osc_freq_value > osc_freq_hi);
  wire gain_bad = (gain_now <= gain_lo) || (gain_now >= gain_hi);

  reg [WD_W-1:0] wd_count;
  reg            wd_expire;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_count  <= {WD_W{1'b0}};
      wd_expire <= 1'b0;
    end else begin
      wd_expire <= 1'b0;
      if (wd_value == {WD_W{1'b0}}) begin
        wd_count <= {WD_W{1'b0}};
      end else if (wd_count >= wd_value - 1'b1) begin
        wd_count  <= {WD_W{1'b0}};
        wd_expire <= 1'b1;
      end else begin
        wd_count <= wd_count + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Output protections
  // ---------------------------------------------------------------------
  wire buf_off;
  wire buf_temp;
  wire buf_sticky;
  wire ovl_off;
  wire ovl_temp;
  wire ovl_sticky;

  dam_retry_guard #(
    .ON_CYCLES  (BUF_CHECK_CYC),
    .OFF_CYCLES (BUF_CHECK_CYC),
    .CNT_W      (20)
  ) u_buf_guard (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .fault_now    (sync_b[15]),
    .clear_sticky (clear_buf_sticky),
    .outputs_off  (buf_off),
    .temp_flag    (buf_temp),
    .sticky_flag  (buf_sticky)
  );

  dam_retry_guard #(
    .ON_CYCLES  (OC_ASSERT_CYC),
    .OFF_CYCLES (OC_RETRY_CYC),
    .CNT_W      (20)
  ) u_ovl_guard (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .fault_now    (sync_b[16]),
    .clear_sticky (clear_ovl_sticky),
    .outputs_off  (ovl_off),
    .temp_flag    (ovl_temp),
    .sticky_flag  (ovl_sticky)
  );

  // ---------------------------------------------------------------------
  // Flag vector
  // ---------------------------------------------------------------------
  reg [NF-1:0] next_flags;

  always @* begin
    next_flags = flags;
    next_flags[`DAM_F_OVERVOLT]      = sync_b[0];
    next_flags[`DAM_F_UNDERVOLT]     = sync_b[1];
    next_flags[`DAM_F_ANA_UNDERVOLT] = sync_b[2];
    next_flags[`DAM_F_DATA_ACCESS]   = sync_b[3];
    next_flags[`DAM_F_PROTOCOL]      = sync_b[4];
    next_flags[`DAM_F_INT_BUS]       = sync_b[5];
    next_flags[`DAM_F_SHADOW_SED]    = sh_sed;
    next_flags[`DAM_F_SHADOW_CODE]   = sh_sed | sh_ded;
    next_flags[`DAM_F_OSC_FREQ]      = freq_bad;
    next_flags[`DAM_F_OSC_STOP]      = sync_b[7];
    next_flags[`DAM_F_RX_COIL]       = sync_b[8];
    next_flags[`DAM_F_TX_COIL]       = sync_b[9];
    next_flags[`DAM_F_JUNC_TEMP]     = sync_b[10];
    next_flags[`DAM_F_GAIN_LOOP]     = gain_bad;
    next_flags[`DAM_F_BUF_TEMP]      = buf_temp;
    next_flags[`DAM_F_OVL_TEMP]      = ovl_temp;
    next_flags[`DAM_F_BUF_STICKY]    = buf_sticky;
    next_flags[`DAM_F_OVL_STICKY]    = ovl_sticky;
    if (nvm_chk) begin
      next_flags[`DAM_F_NVM_SED]  = nv_sed;
      next_flags[`DAM_F_NVM_CODE] = nv_sed | nv_ded;
    end
    // Sticky flags other than the two lockout flags only ever set here; reset is their sole clear.
    next_flags[`DAM_F_SHADOW_DED]  = flags[`DAM_F_SHADOW_DED] | sh_ded;
    next_flags[`DAM_F_NVM_DED]     = flags[`DAM_F_NVM_DED] |
                                     (nvm_chk & nv_ded);
    next_flags[`DAM_F_INT_OSC]     = flags[`DAM_F_INT_OSC] | sync_b[6];
    next_flags[`DAM_F_WATCHDOG]    = flags[`DAM_F_WATCHDOG] | wd_expire;
    next_flags[`DAM_F_MECH_DAMAGE] = flags[`DAM_F_MECH_DAMAGE] | sync_b[11];
    next_flags[`DAM_F_INT_SUPPLY]  = flags[`DAM_F_INT_SUPPLY] | sync_b[12];
    next_flags[`DAM_F_DIGITAL]     = flags[`DAM_F_DIGITAL] | sync_b[13];
    next_flags[`DAM_F_SELF_TEST]   = flags[`DAM_F_SELF_TEST] |
                                     (sync_b[14] & !startup_done);
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags            <= {NF{1'b0}};
      shadow_corrected <= 32'h0000_0000;
      nvm_corrected    <= 32'h0000_0000;
      osc_freq_value   <= {FREQ_W{1'b0}};
    end else begin
      flags            <= next_flags;
      shadow_corrected <= sh_fix;
      osc_freq_value   <= osc_freq_meas;
      if (nvm_chk) begin
        nvm_corrected <= nv_fix;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt pin and output diagnostic state
  // ---------------------------------------------------------------------
  wire irq_any  = |(flags & irq_enable);
  wire diag_any = |(flags & diag_enable);

  // Open-drain: the pin is only ever pulled low, never driven high.
  assign irq_pin_out  = 1'b0;
  assign irq_pin_oe_n = !irq_any;

  wire prot_off = buf_off | ovl_off;
  wire diag_true = diag_any && ((diag_mode == `DAM_DIAG_TRUE) ||
                   (diag_mode == `DAM_DIAG_ALL));
  wire diag_comp = diag_any && ((diag_mode == `DAM_DIAG_COMP) ||
                   (diag_mode == `DAM_DIAG_ALL));

  assign sine_pos_oe_n = prot_off | diag_true;
  assign cos_pos_oe_n  = prot_off | diag_true;
  assign sine_neg_oe_n = prot_off | diag_comp;
  assign cos_neg_oe_n  = prot_off | diag_comp;
endmodule // dam_top

// ==== bench/dam_props.sv ====
// Purpose: Port-level checks on the diagnostic alarm manager.
// Assumes: Flags register one edge after their synchronised cause.
// Notes:   Bound into every dam_top instance.
`timescale 1ns/1ns
module dam_props #(
  parameter NF     = 28,
  parameter FREQ_W = 16,
  parameter GAIN_W = 8
) (
  input wire              sys_clk,
  input wire              rst_n,
  input wire              overvolt_in,
  input wire              undervolt_in,
  input wire [FREQ_W-1:0] osc_freq_meas,
  input wire [FREQ_W-1:0] osc_freq_lo,
  input wire [FREQ_W-1:0] osc_freq_hi,
  input wire [GAIN_W-1:0] gain_now,
  input wire [GAIN_W-1:0] gain_lo,
  input wire [GAIN_W-1:0] gain_hi,
  input wire [NF-1:0]     irq_enable,
  input wire [NF-1:0]     diag_enable,
  input wire [1:0]        diag_mode,
  input wire              clear_buf_sticky,
  input wire              clear_ovl_sticky,
  input wire [NF-1:0]     flags,
  input wire              irq_pin_oe_n,
  input wire              sine_pos_oe_n,
  input wire              sine_neg_oe_n,
  input wire              cos_pos_oe_n,
  input wire              cos_neg_oe_n
);
  localparam [NF-1:0] STICKY = 28'h340_68a0;
  wire off4 = sine_pos_oe_n & sine_neg_oe_n & cos_pos_oe_n & cos_neg_oe_n;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_irq_level: assert property (irq_pin_oe_n == ~|(flags & irq_enable))
    else $error("irq pin does not follow enabled flags");
  a_sticky_hold: assert property (($past(flags) & STICKY & ~flags) == 0)
    else $error("sticky flag dropped");
  a_ov_set: assert property (overvolt_in [*4] |-> flags[0])
    else $error("overvoltage flag missing");
  a_uv_clear: assert property (!undervolt_in [*4] |-> !flags[1])
    else $error("undervoltage flag stuck");
  a_gain_limit: assert property ($past(rst_n) |-> flags[23] ==
    $past(gain_now <= gain_lo || gain_now >= gain_hi))
    else $error("gain flag wrong");
  a_freq_window: assert property ($past(rst_n, 2) |-> flags[9] ==
    ($past(osc_freq_meas, 2) < $past(osc_freq_lo) ||
     $past(osc_freq_meas, 2) > $past(osc_freq_hi)))
    else $error("frequency flag wrong");
  a_ovl_lockout: assert property (flags[18] && !clear_ovl_sticky |-> off4)
    else $error("outputs on during overload lockout");
  a_buf_lockout: assert property (flags[16] && !clear_buf_sticky |-> off4)
    else $error("outputs on during offset lockout");
  a_diag_select: assert property (|(flags & diag_enable) |->
    (!diag_mode[0] || sine_pos_oe_n && cos_pos_oe_n) &&
    (!diag_mode[1] || sine_neg_oe_n && cos_neg_oe_n))
    else $error("selected outputs not switched off");
endmodule // dam_props

bind dam_top dam_props #(.NF(NF), .FREQ_W(FREQ_W), .GAIN_W(GAIN_W)) u_props (
  .sys_clk, .rst_n, .overvolt_in, .undervolt_in, .osc_freq_meas,
  .osc_freq_lo, .osc_freq_hi, .gain_now, .gain_lo, .gain_hi, .irq_enable,
  .diag_enable, .diag_mode, .clear_buf_sticky, .clear_ovl_sticky, .flags,
  .irq_pin_oe_n, .sine_pos_oe_n, .sine_neg_oe_n, .cos_pos_oe_n,
  .cos_neg_oe_n);

// ==== bench/dam_mcu_model.sv ====
// Purpose: Receiving controller watching the interrupt and output pins.
// Assumes: Pull-up resistors on every pin at the receiver.
// Notes:   Issues sticky clears when the bench asks for them.
`timescale 1ns/1ns
module dam_mcu_model (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       irq_pin_out,
  input  wire       irq_pin_oe_n,
  input  wire [3:0] out_oe_n,
  input  wire [1:0] clear_req,
  output wire       irq_level,
  output wire [3:0] diag_high,
  output reg        clear_buf_sticky,
  output reg        clear_ovl_sticky
);
  // A released pin is pulled high, so a driver that is off reads diagnostic.
  assign irq_level = irq_pin_oe_n ? 1'b1 : irq_pin_out;
  assign diag_high = out_oe_n;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clear_buf_sticky <= 1'b0;
      clear_ovl_sticky <= 1'b0;
    end else begin
      clear_buf_sticky <= clear_req[0];
      clear_ovl_sticky <= clear_req[1];
    end
  end
endmodule // dam_mcu_model

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for the diagnostic alarm manager.
// Assumes: Short debounce windows; pins seen through the controller model.
// Notes:   Random fault patterns mixed with boundary and lockout cases.
`timescale 1ns/1ns
`include "dam_defines.vh"
module testbench;
  reg  [16:0] flt;
  reg  [1:0]  clr, diag_mode;
  reg         sys_clk, rst_n, nvm_valid;
  reg  [31:0] shadow_data, nvm_data, r;
  reg  [6:0]  shadow_check, nvm_check;
  reg  [15:0] osc_freq_meas, osc_freq_lo, osc_freq_hi;
  reg  [7:0]  gain_now, gain_lo, gain_hi;
  reg  [23:0] wd_value;
  reg  [27:0] irq_enable, diag_enable;
  wire [27:0] flags;
  wire [31:0] shadow_corrected, nvm_corrected;
  wire [15:0] osc_freq_value;
  wire [3:0]  diag_high;
  wire        startup_done, irq_pin_out, irq_pin_oe_n, irq_level;
  wire        sine_pos_oe_n, sine_neg_oe_n, cos_pos_oe_n, cos_neg_oe_n;
  wire        clear_buf_sticky, clear_ovl_sticky;
  int         errors, n_checks, i;

  dam_top #(.OC_ASSERT_CYC(4), .OC_RETRY_CYC(8), .BUF_CHECK_CYC(4)) dut (
    .sys_clk, .rst_n, .overvolt_in(flt[0]), .undervolt_in(flt[1]),
    .ana_undervolt_in(flt[2]), .data_access_in(flt[3]),
    .protocol_fail_in(flt[4]), .int_bus_in(flt[5]), .osc_stop_in(flt[6]),
    .rx_coil_in(flt[7]), .tx_coil_in(flt[8]), .junc_temp_in(flt[9]),
    .int_osc_fail_in(flt[10]), .mech_damage_in(flt[11]),
    .int_supply_in(flt[12]), .digital_err_in(flt[13]),
    .self_test_fail_in(flt[14]), .mean_offset_in(flt[15]),
    .overcurrent_in(flt[16]), .shadow_data, .shadow_check,
    .shadow_corrected, .nvm_data, .nvm_check, .nvm_valid, .nvm_corrected,
    .osc_freq_meas, .osc_freq_lo, .osc_freq_hi, .osc_freq_value, .gain_now,
    .gain_lo, .gain_hi, .wd_value, .irq_enable, .diag_enable, .diag_mode,
    .clear_buf_sticky, .clear_ovl_sticky, .flags, .startup_done,
    .irq_pin_out, .irq_pin_oe_n, .sine_pos_oe_n, .sine_neg_oe_n,
    .cos_pos_oe_n, .cos_neg_oe_n);
  dam_mcu_model mcu (.sys_clk, .rst_n, .irq_pin_out, .irq_pin_oe_n,
    .out_oe_n({sine_pos_oe_n, cos_pos_oe_n, sine_neg_oe_n, cos_neg_oe_n}),
    .clear_req(clr), .irq_level, .diag_high, .clear_buf_sticky,
    .clear_ovl_sticky);

  // Flag positions of the self-clearing fault inputs flt[9:0], in order.
  function automatic [27:0] tmap(input [9:0] v);
    int k;
    int fi [10] = '{0, 1, 2, 3, 4, 12, 10, 19, 20, 21};
    tmap = 0;
    for (k = 0; k < 10; k++) tmap[fi[k]] = v[k];
  endfunction
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task print_verdict;
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #300000;
    errors++;
    print_verdict;
  end
  initial begin
    errors = 0; n_checks = 0; rst_n = 0; flt = 0; clr = 0; wd_value = 0;
    shadow_data = 0; shadow_check = 0; nvm_check = 0;
    nvm_data = 32'h0000_0003; nvm_valid = 1;
    osc_freq_meas = 16'h0100; osc_freq_lo = 16'h0080; osc_freq_hi = 16'h0200;
    gain_now = 8'h80; gain_lo = 8'h10; gain_hi = 8'hf0;
    irq_enable = 0; diag_enable = 0; diag_mode = 0;
    void'($urandom(32'h4a07));
    cyc(8);
    rst_n = 1;
    cyc(4);
    chk("nvm_ded", flags[`DAM_F_NVM_DED], 1);
    nvm_data = 32'h0000_0001;
    cyc(2);
    chk("nvm_fix", nvm_corrected, 0);
    chk("nvm_sed", flags[`DAM_F_NVM_SED], 1);
    nvm_valid = 0;
    chk("early_start", startup_done, 0);
    repeat (40) if (!startup_done) cyc(1);
    chk("start_done", startup_done, 1);
    flt[14] = 1; nvm_valid = 1; nvm_data = 0;
    cyc(6);
    chk("late_selftest", flags[`DAM_F_SELF_TEST], 0);
    chk("late_nvm", flags[`DAM_F_NVM_SED], 1);
    flt[14] = 0; nvm_valid = 0;
    for (i = 0; i < 4; i++) begin
      shadow_data = (i == 0) ? 1 : (i == 2) ? 3 : 0;
      cyc(2);
      chk("shadow_sed", flags[`DAM_F_SHADOW_SED], i == 0);
      chk("shadow_ded", flags[`DAM_F_SHADOW_DED], i >= 2);
      if (i < 2) chk("shadow_fix", shadow_corrected, 0);
      if (i == 0) chk("shadow_code", flags[26], 1);
    end
    for (i = 0; i < 40; i++) begin
      r = (i == 0) ? 32'hffff_ffff : (i == 1) ? 0 : $urandom;
      flt[9:0] = r[9:0];
      irq_enable = tmap(r[19:10]);
      gain_lo = {4'h0, r[23:20]}; gain_hi = {4'hf, r[27:24]};
      osc_freq_lo = {8'h00, r[31:24]}; osc_freq_hi = {8'h02, r[7:0]};
      cyc(4);
      chk("temp_flags", flags & tmap(10'h3ff), tmap(r[9:0]));
      chk("irq_pin", irq_level, ~|(tmap(r[9:0]) & irq_enable));
    end
    flt = 0;
    for (i = 0; i < 4; i++) begin
      gain_now = i[0] ? gain_hi - i[1] : gain_lo + i[1];
      osc_freq_meas = i[0] ? osc_freq_hi + !i[1] : osc_freq_lo - !i[1];
      cyc(2);
      chk("gain_flag", flags[`DAM_F_GAIN_LOOP], !i[1]);
      chk("freq_flag", flags[`DAM_F_OSC_FREQ], !i[1]);
      chk("freq_value", osc_freq_value, osc_freq_meas);
    end
    gain_now = 8'h80; osc_freq_meas = 16'h0100; flt[13:10] = 4'hf;
    cyc(4);
    flt = 0;
    cyc(6);
    chk("sticky_set", flags & 28'h140_4800, 28'h140_4800);
    diag_enable = 28'h000_4000;
    for (i = 0; i < 5; i++) begin
      diag_mode = i[1:0];
      if (i == 4) diag_enable = 28'h000_0001;
      cyc(1);
      chk("diag_pins", diag_high, i[2] ? 0 : {{2{i[0]}}, {2{i[1]}}});
    end
    diag_mode = 0; diag_enable = 0;
    chk("wd_idle", flags[`DAM_F_WATCHDOG], 0);
    wd_value = 24'h00_0014;
    cyc(10);
    chk("wd_early", flags[`DAM_F_WATCHDOG], 0);
    cyc(20);
    chk("wd_fire", flags[`DAM_F_WATCHDOG], 1);
    wd_value = 0; irq_enable = 28'h000_2000;
    cyc(1);
    chk("wd_irq", irq_level, 0);
    for (i = 0; i < 2; i++) begin
      flt[15 + i] = 1;
      cyc(9);
      chk("prot_off", diag_high, 4'hf);
      chk("temp_flag", flags[15 + 2 * i], 1);
      cyc(300);
      chk("lock_flag", flags[16 + 2 * i], 1);
      flt[15 + i] = 0;
      cyc(20);
      chk("lock_off", diag_high, 4'hf);
      clr[i] = 1;
      cyc(3);
      clr[i] = 0;
      cyc(5);
      chk("unlock_pins", diag_high, 0);
      chk("unlock_flag", flags[16 + 2 * i], 0);
    end
    print_verdict;
  end
endmodule // testbench
